/* File: rtl/meter_frontend_config_bank.sv */
// Contract
// - write-only bits read back as zero.
// - boot region end is 1024 times the boot size field, which is 01 at reset and wake.
// - engine program start is 1024 times the base field, which is 0x31 at reset and wake.
// - engine clock is 10 MHz when the fast select bit is set, else 5 MHz.
// - the reference chop state changes only on a rising mux sync edge, per the chop field; wake also clears it to 0.
// - chop 00 toggles except at summation end and inserts an alternate frame; 01 positive; 10 reversed; 11 toggles only.
// - each channel current chop bit acts only while the global current chop bit is set.
// - setting battery measure enable at once loads the battery and routes it to the converter.
// - converter enable, cleared at reset and wake, powers converter and reference.
// - nonvolatile bits keep their value across wake.
// - retained display bits survive display-only and brownout transitions but not sleep.
// - engine enable and fast clock select are cleared by reset and by wake.
`timescale 1ns/1ps
module meter_frontend_config_bank
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wake_i,
  input  wire logic        sleep_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        mux_frame_sync_i,
  input  wire logic        summation_cycle_i,
  input  wire logic        accum_done_i,
  output logic [7:0]       rdata_o,
  output logic             engine_enable_o,
  output logic             engine_clk_o,
  output logic             converter_enable_o,
  output logic             battery_measure_enable_o,
  output logic             ref_chop_o,
  output logic             alternate_frame_request_o,
  output logic [3:0]       current_chop_o,
  output logic [17:0]      boot_end_addr_o,
  output logic [17:0]      engine_start_addr_o
);
  logic       engine_en_r, engine_en_nxt;
  logic       engine_fast_r, engine_fast_nxt;
  logic [1:0] chop_mode_r, chop_mode_nxt;
  logic       conv_en_r, conv_en_nxt;
  logic       batt_en_r, batt_en_nxt;
  logic [7:0] boot_size_r, boot_size_nxt;
  logic [7:0] engine_base_r, engine_base_nxt;
  logic       chop_global_r, chop_global_nxt;
  logic [3:0] chop_ch_r, chop_ch_nxt;
  logic       sync_d_r;
  logic       ref_chop_r, ref_chop_nxt;
  logic       alt_req_r, alt_req_nxt;
  logic       alt_pending_r, alt_pending_nxt;
  logic [7:0] rdata_nxt;
  logic [3:0] cur_chop_nxt;
  logic       sync_rise;
  logic       eck_q;
  engine_clk_if eck ();

  assign sync_rise = mux_frame_sync_i && !sync_d_r;

  always_comb
  begin
    engine_en_nxt   = engine_en_r;
    engine_fast_nxt = engine_fast_r;
    chop_mode_nxt   = chop_mode_r;
    conv_en_nxt     = conv_en_r;
    batt_en_nxt     = batt_en_r;
    boot_size_nxt   = boot_size_r;
    engine_base_nxt = engine_base_r;
    chop_global_nxt = chop_global_r;
    chop_ch_nxt     = chop_ch_r;
    if (wake_i)
    begin
      engine_en_nxt   = 1'b0;
      engine_fast_nxt = 1'b0;
      chop_mode_nxt   = 2'h0;
      conv_en_nxt     = 1'b0;
      boot_size_nxt   = meter_cfg_pkg::RST_BOOT_SIZE;
      engine_base_nxt = meter_cfg_pkg::RST_ENGINE_BASE;
      chop_global_nxt = 1'b0;
      chop_ch_nxt     = 4'h0;
      // no retained display bits in this bank
    end
    else if (wr_i)
    begin
      unique case (addr_i)
        meter_cfg_pkg::ADDR_ENGINE_CLOCK:
        begin
          engine_en_nxt   = wdata_i[meter_cfg_pkg::BIT_ENGINE_EN];
          engine_fast_nxt = wdata_i[meter_cfg_pkg::BIT_ENGINE_FAST];
        end
        meter_cfg_pkg::ADDR_REF_CHOP:
          chop_mode_nxt = wdata_i[meter_cfg_pkg::BIT_CHOP_LO +: 2];
        meter_cfg_pkg::ADDR_CONV_POWER:
          conv_en_nxt = wdata_i[meter_cfg_pkg::BIT_CONV_EN];
        meter_cfg_pkg::ADDR_BATTERY:
          batt_en_nxt = wdata_i[meter_cfg_pkg::BIT_BATT_EN];
        meter_cfg_pkg::ADDR_BOOT_SIZE:
          boot_size_nxt = wdata_i;
        meter_cfg_pkg::ADDR_ENGINE_BASE:
          engine_base_nxt = wdata_i;
        meter_cfg_pkg::ADDR_CHOP_GLOBAL:
          chop_global_nxt = wdata_i[meter_cfg_pkg::BIT_CHOP_GLOBAL];
        meter_cfg_pkg::ADDR_CHOP_AB:
        begin
          chop_ch_nxt[0] = wdata_i[meter_cfg_pkg::BIT_CHOP_LOW_CH];
          chop_ch_nxt[1] = wdata_i[meter_cfg_pkg::BIT_CHOP_HIGH_CH];
        end
        meter_cfg_pkg::ADDR_CHOP_CD:
        begin
          chop_ch_nxt[2] = wdata_i[meter_cfg_pkg::BIT_CHOP_LOW_CH];
          chop_ch_nxt[3] = wdata_i[meter_cfg_pkg::BIT_CHOP_HIGH_CH];
        end
        default:
        begin
        end
      endcase
    end
  end

  // read mux; unmapped reads zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (rd_i)
    begin
      // no write-only bit exists here; reserved bits zero
      unique case (addr_i)
        meter_cfg_pkg::ADDR_ENGINE_CLOCK:
        begin
          rdata_nxt[meter_cfg_pkg::BIT_ENGINE_EN]   = engine_en_r;
          rdata_nxt[meter_cfg_pkg::BIT_ENGINE_FAST] = engine_fast_r;
        end
        meter_cfg_pkg::ADDR_REF_CHOP:
          rdata_nxt[meter_cfg_pkg::BIT_CHOP_LO +: 2] = chop_mode_r;
        meter_cfg_pkg::ADDR_CONV_POWER:
          rdata_nxt[meter_cfg_pkg::BIT_CONV_EN] = conv_en_r;
        meter_cfg_pkg::ADDR_BATTERY:
          rdata_nxt[meter_cfg_pkg::BIT_BATT_EN] = batt_en_r;
        meter_cfg_pkg::ADDR_BOOT_SIZE:
          rdata_nxt = boot_size_r;
        meter_cfg_pkg::ADDR_ENGINE_BASE:
          rdata_nxt = engine_base_r;
        meter_cfg_pkg::ADDR_CHOP_GLOBAL:
          rdata_nxt[meter_cfg_pkg::BIT_CHOP_GLOBAL] = chop_global_r;
        meter_cfg_pkg::ADDR_CHOP_AB:
        begin
          rdata_nxt[meter_cfg_pkg::BIT_CHOP_LOW_CH]  = chop_ch_r[0];
          rdata_nxt[meter_cfg_pkg::BIT_CHOP_HIGH_CH] = chop_ch_r[1];
        end
        meter_cfg_pkg::ADDR_CHOP_CD:
        begin
          rdata_nxt[meter_cfg_pkg::BIT_CHOP_LOW_CH]  = chop_ch_r[2];
          rdata_nxt[meter_cfg_pkg::BIT_CHOP_HIGH_CH] = chop_ch_r[3];
        end
        default:
          rdata_nxt = 8'h00;
      endcase
    end
  end

  // reference chop sequencing
  always_comb
  begin
    ref_chop_nxt    = ref_chop_r;
    alt_req_nxt     = 1'b0;
    alt_pending_nxt = alt_pending_r;
    if (chop_mode_r == 2'(meter_cfg_pkg::CHOP_AUTO_ALT) && accum_done_i)
      alt_pending_nxt = 1'b1;
    // a pending frame is dropped once the mode leaves 00
    else if (chop_mode_r != 2'(meter_cfg_pkg::CHOP_AUTO_ALT))
      alt_pending_nxt = 1'b0;
    if (wake_i)
    begin
      ref_chop_nxt    = 1'b0;
      alt_pending_nxt = 1'b0;
    end
    else if (sync_rise)
    begin
      unique case (chop_mode_r)
        2'(meter_cfg_pkg::CHOP_AUTO_ALT):
        begin
          if (!summation_cycle_i)
            ref_chop_nxt = ~ref_chop_r;
          alt_req_nxt     = alt_pending_r || accum_done_i;
          alt_pending_nxt = 1'b0;
        end
        2'(meter_cfg_pkg::CHOP_POSITIVE):
          ref_chop_nxt = 1'b0;
        2'(meter_cfg_pkg::CHOP_REVERSED):
          ref_chop_nxt = 1'b1;
        2'(meter_cfg_pkg::CHOP_TOGGLE):
          ref_chop_nxt = ~ref_chop_r;
      endcase
    end
  end

  assign cur_chop_nxt = chop_global_nxt ? chop_ch_nxt : 4'h0;

  assign eck.fast_sel = engine_fast_r;
  assign eck.enable   = engine_en_r;

  engine_clk_gen u_clk
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .eck   (eck)
  );

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      engine_en_r   <= 1'b0;
      engine_fast_r <= 1'b0;
      chop_mode_r   <= 2'h0;
      conv_en_r     <= 1'b0;
      batt_en_r     <= 1'b0;
      boot_size_r   <= meter_cfg_pkg::RST_BOOT_SIZE;
      engine_base_r <= meter_cfg_pkg::RST_ENGINE_BASE;
      chop_global_r <= 1'b0;
      chop_ch_r     <= 4'h0;
      sync_d_r      <= 1'b0;
      ref_chop_r    <= 1'b0;
      alt_req_r     <= 1'b0;
      alt_pending_r <= 1'b0;
      rdata_o       <= 8'h00;
      engine_enable_o           <= 1'b0;
      engine_clk_o              <= 1'b0;
      converter_enable_o        <= 1'b0;
      battery_measure_enable_o  <= 1'b0;
      ref_chop_o                <= 1'b0;
      alternate_frame_request_o <= 1'b0;
      current_chop_o            <= 4'h0;
      boot_end_addr_o           <= {meter_cfg_pkg::RST_BOOT_SIZE, 10'h000};
      engine_start_addr_o       <= {meter_cfg_pkg::RST_ENGINE_BASE, 10'h000};
    end
    else
    begin
      engine_en_r   <= engine_en_nxt;
      engine_fast_r <= engine_fast_nxt;
      chop_mode_r   <= chop_mode_nxt;
      conv_en_r     <= conv_en_nxt;
      batt_en_r     <= batt_en_nxt;
      boot_size_r   <= boot_size_nxt;
      engine_base_r <= engine_base_nxt;
      chop_global_r <= chop_global_nxt;
      chop_ch_r     <= chop_ch_nxt;
      sync_d_r      <= mux_frame_sync_i;
      ref_chop_r    <= ref_chop_nxt;
      alt_req_r     <= alt_req_nxt;
      alt_pending_r <= alt_pending_nxt;
      rdata_o       <= rdata_nxt;
      engine_enable_o <= engine_en_nxt;
      engine_clk_o    <= eck.clk_out;
      converter_enable_o <= conv_en_nxt;
      battery_measure_enable_o  <= batt_en_nxt;
      ref_chop_o                <= ref_chop_nxt;
      alternate_frame_request_o <= alt_req_nxt;
      current_chop_o            <= cur_chop_nxt;
      boot_end_addr_o     <= {boot_size_nxt, 10'h000};
      engine_start_addr_o <= {engine_base_nxt, 10'h000};
    end
  end

  assign eck_q = eck.clk_out;

  chk_boot_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    boot_end_addr_o == 18'(boot_size_r) * 18'(meter_cfg_pkg::REGION_UNIT_BYTES))
    else $error("boot end address wrong");
  chk_engine_base: assert property (@(posedge clk_i) disable iff (rst_i)
    engine_start_addr_o == 18'(engine_base_r) * 18'(meter_cfg_pkg::REGION_UNIT_BYTES))
    else $error("engine start address wrong");
  chk_wake_defaults: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_i |=> !engine_en_r && !engine_fast_r && boot_size_r == meter_cfg_pkg::RST_BOOT_SIZE
               && engine_base_r == meter_cfg_pkg::RST_ENGINE_BASE && !conv_en_r)
    else $error("wake values wrong");
  chk_wake_keeps_nv: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_i |=> batt_en_r == $past(batt_en_r))
    else $error("battery bit lost on wake");
  chk_chop_edge_only: assert property (@(posedge clk_i) disable iff (rst_i)
    !sync_rise && !wake_i |=> ref_chop_r == $past(ref_chop_r))
    else $error("chop moved without sync edge");
  chk_chop_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
    sync_rise && !wake_i && chop_mode_r == 2'b10 |=> ref_chop_r)
    else $error("reversed chop not applied");
  chk_cur_chop_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !chop_global_r |-> current_chop_o == 4'h0)
    else $error("channel chop without global enable");
  chk_batt_immediate: assert property (@(posedge clk_i) disable iff (rst_i)
    batt_en_r |-> battery_measure_enable_o)
    else $error("battery load late");
  chk_conv_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    converter_enable_o == conv_en_r)
    else $error("converter enable mismatch");
  sequence fast_hi_s;
    $rose(eck_q) ##1 !$changed(eck_q);
  endsequence
  chk_fast_clock: assert property (@(posedge clk_i) disable iff (rst_i)
    engine_en_r && engine_fast_r && $past(engine_fast_r) && $rose(eck_q) |=> $fell(eck_q))
    else $error("fast engine clock not 10 MHz");
  chk_slow_clock: assert property (@(posedge clk_i) disable iff (rst_i)
    engine_en_r && !engine_fast_r && !$past(engine_fast_r) && engine_en_r ##0 fast_hi_s
    |=> $fell(eck_q))
    else $error("slow engine clock not 5 MHz");
  chk_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == meter_cfg_pkg::ADDR_CHOP_GLOBAL |=> rdata_o[7:1] == 7'h00)
    else $error("reserved bits not zero");
endmodule // meter_frontend_config_bank

/* File: rtl/meter_cfg_pkg.sv */
package meter_cfg_pkg;
  localparam logic [15:0] ADDR_ENGINE_CLOCK   = 16'h2000;
  localparam logic [15:0] ADDR_REF_CHOP       = 16'h2002;
  localparam logic [15:0] ADDR_CONV_POWER     = 16'h2005;
  localparam logic [15:0] ADDR_BATTERY        = 16'h2020;
  localparam logic [15:0] ADDR_BOOT_SIZE      = 16'h20a7;
  localparam logic [15:0] ADDR_ENGINE_BASE    = 16'h20a8;
  localparam logic [15:0] ADDR_CHOP_GLOBAL    = 16'h20ab;
  localparam logic [15:0] ADDR_CHOP_AB        = 16'h20ac;
  localparam logic [15:0] ADDR_CHOP_CD        = 16'h20ad;
  localparam int          BIT_ENGINE_FAST     = 3;
  localparam int          BIT_ENGINE_EN       = 4;
  localparam int          BIT_CHOP_LO         = 4;
  localparam int          BIT_CONV_EN         = 3;
  localparam int          BIT_BATT_EN         = 6;
  localparam int          BIT_CHOP_GLOBAL     = 0;
  localparam int          BIT_CHOP_LOW_CH     = 0;
  localparam int          BIT_CHOP_HIGH_CH    = 4;
  localparam logic [7:0]  RST_BOOT_SIZE       = 8'h01;
  localparam logic [7:0]  RST_ENGINE_BASE     = 8'h31;
  localparam int          REGION_UNIT_BYTES   = 1024;
  localparam int          SYS_CLK_HZ          = 20000000;
  localparam int          ENGINE_FAST_HZ      = 10000000;
  localparam int          ENGINE_SLOW_HZ      = 5000000;
  localparam int          FAST_HALF_CYCLES    = SYS_CLK_HZ / ENGINE_FAST_HZ / 2;
  localparam int          SLOW_HALF_CYCLES    = SYS_CLK_HZ / ENGINE_SLOW_HZ / 2;
  typedef enum logic [1:0] {
    CHOP_AUTO_ALT = 2'b00,
    CHOP_POSITIVE = 2'b01,
    CHOP_REVERSED = 2'b10,
    CHOP_TOGGLE   = 2'b11
  } chop_mode_t;
endpackage

/* File: rtl/engine_clk_if.sv */
`timescale 1ns/1ps
interface engine_clk_if;
  logic fast_sel;
  logic enable;
  logic clk_out;
  modport ctrl (output fast_sel, output enable, input clk_out);
  modport gen  (input fast_sel, input enable, output clk_out);
endinterface // engine_clk_if

/* File: rtl/engine_clk_gen.sv */
`timescale 1ns/1ps
module engine_clk_gen
(
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  engine_clk_if.gen   eck
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic       ck_r;
  logic       ck_nxt;
  logic [1:0] half;

  // divide 20 MHz to 10 MHz or 5 MHz
  always_comb
  begin
    half    = eck.fast_sel ? 2'(meter_cfg_pkg::FAST_HALF_CYCLES)
                           : 2'(meter_cfg_pkg::SLOW_HALF_CYCLES);
    cnt_nxt = cnt_r;
    ck_nxt  = ck_r;
    if (!eck.enable)
    begin
      cnt_nxt = 2'h0;
      ck_nxt  = 1'b0;
    end
    else if (cnt_r + 2'h1 >= half)
    begin
      cnt_nxt = 2'h0;
      ck_nxt  = ~ck_r;
    end
    else
    begin
      cnt_nxt = cnt_r + 2'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r <= 2'h0;
      ck_r  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      ck_r  <= ck_nxt;
    end
  end

  assign eck.clk_out = ck_r;
endmodule // engine_clk_gen

/* File: verif/meter_frontend_config_bank_test.sv */
`timescale 1ns/1ps
module meter_frontend_config_bank_test;
  logic        clk_i;
  logic        rst_i;
  logic        wake_i;
  logic        sleep_i;
  logic [15:0] addr_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  wdata_i;
  logic        mux_frame_sync_i;
  logic        summation_cycle_i;
  logic        accum_done_i;
  logic [7:0]  rdata_o;
  logic        engine_enable_o;
  logic        engine_clk_o;
  logic        converter_enable_o;
  logic        battery_measure_enable_o;
  logic        ref_chop_o;
  logic        alternate_frame_request_o;
  logic [3:0]  current_chop_o;
  logic [17:0] boot_end_addr_o;
  logic [17:0] engine_start_addr_o;
  int          n_errors;
  int          tests_run;
  int          alt_cnt;
  logic        exp_chop;
  logic [15:0] addr_tab [9] = '{16'h2000, 16'h2002, 16'h2005, 16'h2020, 16'h20a7,
                                16'h20a8, 16'h20ab, 16'h20ac, 16'h20ad};
  logic [7:0]  mask_tab [9] = '{8'h18, 8'h30, 8'h08, 8'h40, 8'hff, 8'hff, 8'h01, 8'h11, 8'h11};
  logic [7:0]  rst_tab  [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h31, 8'h00, 8'h00, 8'h00};

  meter_frontend_config_bank DUT
  (
    .clk_i                     (clk_i),
    .rst_i                     (rst_i),
    .wake_i                    (wake_i),
    .sleep_i                   (sleep_i),
    .addr_i                    (addr_i),
    .wr_i                      (wr_i),
    .rd_i                      (rd_i),
    .wdata_i                   (wdata_i),
    .mux_frame_sync_i          (mux_frame_sync_i),
    .summation_cycle_i         (summation_cycle_i),
    .accum_done_i              (accum_done_i),
    .rdata_o                   (rdata_o),
    .engine_enable_o           (engine_enable_o),
    .engine_clk_o              (engine_clk_o),
    .converter_enable_o        (converter_enable_o),
    .battery_measure_enable_o  (battery_measure_enable_o),
    .ref_chop_o                (ref_chop_o),
    .alternate_frame_request_o (alternate_frame_request_o),
    .current_chop_o            (current_chop_o),
    .boot_end_addr_o           (boot_end_addr_o),
    .engine_start_addr_o       (engine_start_addr_o)
  );

  always #25 clk_i = ~clk_i;

  // counts alternate frame pulses, which last only one cycle
  always @(negedge clk_i)
    if (alternate_frame_request_o === 1'b1)
      alt_cnt <= alt_cnt + 1;

  task automatic stop_test;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s done, errors so far %0d", name, n_errors);
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge clk_i);
    rd_i = 1'b0;
    check(32'(rdata_o), 32'(exp));
  endtask

  task automatic strobe(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask

  // one rising sync edge; summation flag held across it
  task automatic sync_rise(input logic sum);
    @(negedge clk_i);
    summation_cycle_i = sum;
    mux_frame_sync_i = 1'b1;
    @(negedge clk_i);
    mux_frame_sync_i = 1'b0;
    @(negedge clk_i);
    summation_cycle_i = 1'b0;
  endtask

  task automatic clk_period(input int exp_ns);
    time t1;
    @(posedge engine_clk_o);
    t1 = $time;
    @(posedge engine_clk_o);
    check(32'($time - t1), 32'(exp_ns));
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    $display("watchdog expired at %0t", $time);
    stop_test();
  end

  initial
  begin
    {clk_i, wake_i, sleep_i, wr_i, rd_i, mux_frame_sync_i} = '0;
    {summation_cycle_i, accum_done_i, addr_i, wdata_i} = '0;
    {n_errors, tests_run, alt_cnt} = '0;
    rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 9; i++)
      rd_chk(addr_tab[i], rst_tab[i]);
    check(32'(boot_end_addr_o), 32'h400);
    check(32'(engine_start_addr_o), 32'hc400);
    rd_chk(16'h2001, 8'h00);
    end_test("reset");
    for (int i = 0; i < 9; i++)
    begin
      wr_reg(addr_tab[i], 8'hff);
      rd_chk(addr_tab[i], mask_tab[i]);
    end
    check(32'(boot_end_addr_o), 32'h3fc00);
    check(32'(engine_start_addr_o), 32'h3fc00);
    check(32'({engine_enable_o, converter_enable_o, battery_measure_enable_o}), 32'h7);
    check(32'(current_chop_o), 32'hf);
    clk_period(100);
    wr_reg(16'h2000, 8'h10);
    clk_period(200);
    wr_reg(16'h20ab, 8'h00);
    check(32'(current_chop_o), 32'h0);
    wr_reg(16'h20ac, 8'h01);
    wr_reg(16'h20ab, 8'h01);
    check(32'(current_chop_o), 32'hd);
    wr_reg(16'h20a7, 8'h80);
    check(32'(boot_end_addr_o), 32'h20000);
    end_test("fields");
    exp_chop = 1'b0;
    check(32'(ref_chop_o), 32'(exp_chop));
    sync_rise(1'b0);
    exp_chop = ~exp_chop;
    check(32'(ref_chop_o), 32'(exp_chop));
    mux_frame_sync_i = 1'b1;
    repeat (5) @(negedge clk_i);
    mux_frame_sync_i = 1'b0;
    exp_chop = ~exp_chop;
    check(32'(ref_chop_o), 32'(exp_chop));
    strobe(accum_done_i);
    sync_rise(1'b0);
    exp_chop = ~exp_chop;
    check(32'(ref_chop_o), 32'(exp_chop));
    check(32'(alt_cnt), 32'h0);
    wr_reg(16'h2002, 8'h00);
    sync_rise(1'b0);
    exp_chop = ~exp_chop;
    check(32'(ref_chop_o), 32'(exp_chop));
    sync_rise(1'b1);
    check(32'(ref_chop_o), 32'(exp_chop));
    strobe(accum_done_i);
    sync_rise(1'b0);
    exp_chop = ~exp_chop;
    check(32'(ref_chop_o), 32'(exp_chop));
    check(32'(alt_cnt), 32'h1);
    wr_reg(16'h2002, 8'h10);
    sync_rise(1'b0);
    check(32'(ref_chop_o), 32'h0);
    wr_reg(16'h2002, 8'h20);
    check(32'(ref_chop_o), 32'h0);
    sync_rise(1'b0);
    check(32'(ref_chop_o), 32'h1);
    end_test("chop");
    strobe(wake_i);
    rd_chk(16'h2020, 8'h40);
    rd_chk(16'h2000, 8'h00);
    rd_chk(16'h2005, 8'h00);
    rd_chk(16'h20a7, 8'h01);
    rd_chk(16'h20a8, 8'h31);
    rd_chk(16'h2002, 8'h00);
    rd_chk(16'h20ac, 8'h00);
    check(32'({engine_enable_o, converter_enable_o, battery_measure_enable_o}), 32'h1);
    check(32'(engine_start_addr_o), 32'hc400);
    end_test("wake");
    stop_test();
  end
endmodule // meter_frontend_config_bank_test
